/* File: design/arfga_top.sv */
/*
 * arfga_top: result byte pair formatting, sample accumulation and
 * write-only indirect access to the three gain registers.
 * assumes: samples come from the converter core on the system clock as
 * one-cycle pulses; software uses the plain register port, one strobe
 * per cycle, read data returned in the following cycle.
 */
`timescale 1ns/1ps

// Functional notes
// - single conversion gives 12-bit code, refreshed each time
// - justify bit picks low or high alignment of a single conversion, series sums ignore it
// - unused result bits read zero after a conversion, software result writes can set them
// - series sum shown only after last sample
// - series of 4, 8, 16 samples accumulated
// - series length from config repeat field
// - constant input sum equals code shifted left
// - gain mode: high byte addresses, low loads
// - three gain registers, write only
// - gain addresses 04 upper, 07 nibble, 08 add
// - config bit 0 enables gain access mode
module arfga_top
   import arfga_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rd_data_o,
   input  wire logic [11:0] sample_i,
   input  wire logic        sample_valid_i,
   output logic      [15:0] result_o,
   output logic             result_ready_o,
   output logic             gain_access_o,
   output logic      [7:0]  gain_upper_o,
   output logic      [3:0]  gain_lower_o,
   output logic             gain_add_o
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0]  config_reg;
      logic [7:0]  control_reg;
      logic [15:0] result;
      logic [7:0]  gain_sel;
      logic [7:0]  gain_upper;
      logic [3:0]  gain_lower;
      logic        gain_add;
      logic        new_flag;
      logic        gconv_flag;
      logic        ready;
      logic [7:0]  rdata;
   } arfga_top_st_t;

   arfga_top_st_t st_r;
   arfga_top_st_t st_nxt;

   arfga_acc_if acc_link ();

   // ==========================================================
   // accumulator
   arfga_accum u_accum (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .acc     (acc_link)
   );

   logic        gain_en;
   logic        justify_left;
   logic [1:0]  repeat_count_field;
   logic        wr_config;
   logic        wr_control;
   logic        wr_res_hi;
   logic        wr_res_lo;
   logic        wr_status;
   logic        rd_res_lo;
   logic [15:0] formatted;
   logic [7:0]  status_byte;

   // ==========================================================
   // decode
   assign gain_en            = st_r.config_reg[ARFGA_CFG_GAIN_EN_BIT];
   assign repeat_count_field = st_r.config_reg[ARFGA_CFG_RPT_LSB +: 2];
   assign justify_left       = st_r.control_reg[ARFGA_CTL_JUSTIFY_BIT];

   assign wr_config  = wr_i && (addr_i == ARFGA_OFF_CONFIG);
   assign wr_control = wr_i && (addr_i == ARFGA_OFF_CONTROL);
   assign wr_res_hi  = wr_i && (addr_i == ARFGA_OFF_RES_HI);
   assign wr_res_lo  = wr_i && (addr_i == ARFGA_OFF_RES_LO);
   assign wr_status  = wr_i && (addr_i == ARFGA_OFF_STATUS);
   assign rd_res_lo  = rd_i && (addr_i == ARFGA_OFF_RES_LO);

   // ==========================================================
   // accumulator link
   assign acc_link.sample       = sample_i;
   assign acc_link.sample_valid = sample_valid_i;
   assign acc_link.rpt          = repeat_count_field;
   // a new series length drops any partial series
   assign acc_link.clear        = wr_config &&
                                  (wr_data_i[ARFGA_CFG_RPT_LSB +: 2] != repeat_count_field);

   // ==========================================================
   // result formatting
   always_comb begin
      if (repeat_count_field != 2'h0) begin
         formatted = acc_link.total;
      end else if (justify_left) begin
         formatted = {acc_link.total[11:0], 4'h0};
      end else begin
         formatted = {4'h0, acc_link.total[11:0]};
      end
   end

   // ==========================================================
   // status byte
   always_comb begin
      status_byte                         = 8'h00;
      status_byte[ARFGA_STS_BUSY_BIT]     = acc_link.busy;
      status_byte[ARFGA_STS_NEW_BIT]      = st_r.new_flag;
      status_byte[ARFGA_STS_GCONV_BIT]    = st_r.gconv_flag;
      status_byte[ARFGA_STS_IDX_LSB +: 4] = acc_link.idx;
   end

   // ==========================================================
   // next state
   always_comb begin
      st_nxt       = st_r;
      st_nxt.ready = 1'b0;
      st_nxt.rdata = 8'h00;

      // configuration and control
      if (wr_config) begin
         st_nxt.config_reg = wr_data_i & ARFGA_CFG_MASK;
      end
      if (wr_control) begin
         st_nxt.control_reg = wr_data_i & ARFGA_CTL_MASK;
      end

      // result pair writes or indirect gain access
      if (wr_res_hi) begin
         if (gain_en) begin
            st_nxt.gain_sel = wr_data_i;
         end else begin
            st_nxt.result[15:8] = wr_data_i;
         end
      end
      if (wr_res_lo) begin
         if (gain_en) begin
            case (st_r.gain_sel)
               ARFGA_GADDR_UPPER: begin
                  st_nxt.gain_upper = wr_data_i;
               end
               ARFGA_GADDR_LOWER: begin
                  st_nxt.gain_lower = wr_data_i[ARFGA_GAIN_NIBBLE_LSB +: 4];
               end
               ARFGA_GADDR_ADD: begin
                  st_nxt.gain_add = wr_data_i[ARFGA_GAIN_ADD_BIT];
               end
               default: begin
                  st_nxt.gain_add = st_r.gain_add;
               end
            endcase
         end else begin
            st_nxt.result[7:0] = wr_data_i;
         end
      end

      // flags: hardware set wins over software clear
      if (rd_res_lo) begin
         st_nxt.new_flag = 1'b0;
      end
      if (wr_status && wr_data_i[ARFGA_STS_GCONV_BIT]) begin
         st_nxt.gconv_flag = 1'b0;
      end
      if (sample_valid_i && gain_en) begin
         st_nxt.gconv_flag = 1'b1;
      end

      // conversion update wins over a software write
      if (acc_link.done) begin
         st_nxt.result   = formatted;
         st_nxt.new_flag = 1'b1;
         st_nxt.ready    = 1'b1;
      end

      // read data, gain registers never read back
      if (rd_i) begin
         case (addr_i)
            ARFGA_OFF_CONFIG: begin
               st_nxt.rdata = st_r.config_reg;
            end
            ARFGA_OFF_CONTROL: begin
               st_nxt.rdata = st_r.control_reg;
            end
            ARFGA_OFF_RES_HI: begin
               st_nxt.rdata = st_r.result[15:8];
            end
            ARFGA_OFF_RES_LO: begin
               st_nxt.rdata = st_r.result[7:0];
            end
            ARFGA_OFF_STATUS: begin
               st_nxt.rdata = status_byte;
            end
            default: begin
               st_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r.config_reg  <= ARFGA_CONFIG_RST;
         st_r.control_reg <= ARFGA_CONTROL_RST;
         st_r.result      <= ARFGA_RESULT_RST;
         st_r.gain_sel    <= ARFGA_GSEL_RST;
         st_r.gain_upper  <= ARFGA_GUPPER_RST;
         st_r.gain_lower  <= ARFGA_GLOWER_RST;
         st_r.gain_add    <= 1'b0;
         st_r.new_flag    <= 1'b0;
         st_r.gconv_flag  <= 1'b0;
         st_r.ready       <= 1'b0;
         st_r.rdata       <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign rd_data_o      = st_r.rdata;
   assign result_o       = st_r.result;
   assign result_ready_o = st_r.ready;
   assign gain_access_o  = st_r.config_reg[ARFGA_CFG_GAIN_EN_BIT];
   assign gain_upper_o   = st_r.gain_upper;
   assign gain_lower_o   = st_r.gain_lower;
   assign gain_add_o     = st_r.gain_add;

endmodule // arfga_top

/* File: design/arfga_pkg.sv */
/*
 * arfga_pkg: constants, field layout, reset values and types of the
 * converter result formatting and gain access block.
 * assumes: one system clock, registers reached over a plain byte port.
 */
package arfga_pkg;

   // ==========================================================
   // widths
   localparam int unsigned ARFGA_CODE_W = 12;
   localparam int unsigned ARFGA_SUM_W  = 16;
   localparam int unsigned ARFGA_ADDR_W = 8;
   localparam int unsigned ARFGA_DATA_W = 8;

   // ==========================================================
   // register offsets
   localparam logic [7:0] ARFGA_OFF_CONFIG  = 8'h00;
   localparam logic [7:0] ARFGA_OFF_CONTROL = 8'h01;
   localparam logic [7:0] ARFGA_OFF_RES_HI  = 8'h02;
   localparam logic [7:0] ARFGA_OFF_RES_LO  = 8'h03;
   localparam logic [7:0] ARFGA_OFF_STATUS  = 8'h04;

   // ==========================================================
   // field positions
   localparam int unsigned ARFGA_CFG_GAIN_EN_BIT  = 0;
   localparam int unsigned ARFGA_CFG_RPT_LSB      = 1;
   localparam int unsigned ARFGA_CTL_JUSTIFY_BIT  = 2;
   localparam int unsigned ARFGA_STS_BUSY_BIT     = 0;
   localparam int unsigned ARFGA_STS_NEW_BIT      = 1;
   localparam int unsigned ARFGA_STS_GCONV_BIT    = 2;
   localparam int unsigned ARFGA_STS_IDX_LSB      = 4;
   localparam int unsigned ARFGA_GAIN_NIBBLE_LSB  = 4;
   localparam int unsigned ARFGA_GAIN_ADD_BIT     = 0;
   localparam logic [7:0]  ARFGA_CFG_MASK         = 8'h07;
   localparam logic [7:0]  ARFGA_CTL_MASK         = 8'h04;

   // ==========================================================
   // indirect gain addresses
   localparam logic [7:0] ARFGA_GADDR_UPPER = 8'h04;
   localparam logic [7:0] ARFGA_GADDR_LOWER = 8'h07;
   localparam logic [7:0] ARFGA_GADDR_ADD   = 8'h08;

   // ==========================================================
   // reset values
   localparam logic [7:0]  ARFGA_CONFIG_RST  = 8'h00;
   localparam logic [7:0]  ARFGA_CONTROL_RST = 8'h00;
   localparam logic [15:0] ARFGA_RESULT_RST  = 16'h0000;
   localparam logic [7:0]  ARFGA_GUPPER_RST  = 8'h00;
   localparam logic [3:0]  ARFGA_GLOWER_RST  = 4'h0;
   localparam logic [7:0]  ARFGA_GSEL_RST    = 8'h00;

   // ==========================================================
   // types
   typedef enum logic [0:0] {ARFGA_ACC_IDLE, ARFGA_ACC_RUN} arfga_acc_state_t;

   // repeat field 0,1,2,3 -> 1,4,8,16 samples; returns index of last sample
   function automatic logic [3:0] arfga_rpt_last(input logic [1:0] rpt);
      case (rpt)
         2'h1:    arfga_rpt_last = 4'h3;
         2'h2:    arfga_rpt_last = 4'h7;
         2'h3:    arfga_rpt_last = 4'hf;
         default: arfga_rpt_last = 4'h0;
      endcase
   endfunction

endpackage

/* File: design/arfga_acc_if.sv */
/*
 * arfga_acc_if: link between the register side and the accumulator.
 * assumes: both ends on the system clock.
 */
`timescale 1ns/1ps
interface arfga_acc_if;
   logic [11:0] sample;
   logic        sample_valid;
   logic [1:0]  rpt;
   logic        clear;
   logic        done;
   logic [15:0] total;
   logic        busy;
   logic [3:0]  idx;

   modport acc (input sample, sample_valid, rpt, clear, output done, total, busy, idx);
   modport ctl (output sample, sample_valid, rpt, clear, input done, total, busy, idx);
endinterface

/* File: design/arfga_accum.sv */
/*
 * arfga_accum: sums a series of 1, 4, 8 or 16 samples.
 * assumes: samples arrive as one-cycle valid pulses on the system clock.
 */
`timescale 1ns/1ps
module arfga_accum
   import arfga_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   arfga_acc_if.acc  acc
);

   typedef struct packed {
      arfga_acc_state_t state;
      logic [3:0]       idx;
      logic [15:0]      sum;
      logic             done;
      logic [15:0]      total;
   } arfga_accum_st_t;

   arfga_accum_st_t st_r;
   arfga_accum_st_t st_nxt;
   logic [15:0]     sum_add;

   // ==========================================================
   // next state
   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      sum_add     = 16'(st_r.sum + {4'h0, acc.sample});
      case (st_r.state)
         ARFGA_ACC_IDLE: begin
            if (acc.sample_valid) begin
               st_nxt.sum = {4'h0, acc.sample};
               if (arfga_rpt_last(acc.rpt) == 4'h0) begin
                  st_nxt.total = {4'h0, acc.sample};
                  st_nxt.done  = 1'b1;
               end else begin
                  st_nxt.idx   = 4'h1;
                  st_nxt.state = ARFGA_ACC_RUN;
               end
            end
         end
         ARFGA_ACC_RUN: begin
            if (acc.sample_valid) begin
               st_nxt.sum = sum_add;
               if (st_r.idx == arfga_rpt_last(acc.rpt)) begin
                  st_nxt.total = sum_add;
                  st_nxt.done  = 1'b1;
                  st_nxt.idx   = 4'h0;
                  st_nxt.state = ARFGA_ACC_IDLE;
               end else begin
                  st_nxt.idx = 4'(st_r.idx + 4'h1);
               end
            end
         end
         default: begin
            st_nxt.state = ARFGA_ACC_IDLE;
         end
      endcase
      if (acc.clear) begin
         st_nxt.state = ARFGA_ACC_IDLE;
         st_nxt.idx   = 4'h0;
         st_nxt.done  = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '{state: ARFGA_ACC_IDLE, idx: 4'h0, sum: ARFGA_RESULT_RST,
                   done: 1'b0, total: ARFGA_RESULT_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign acc.done  = st_r.done;
   assign acc.total = st_r.total;
   assign acc.busy  = (st_r.state == ARFGA_ACC_RUN);
   assign acc.idx   = st_r.idx;

endmodule // arfga_accum

/* File: testbench/arfga_top_assertions.sv */
/* arfga_top_checker: port assertions on arfga_top.
   assumes: bound to arfga_top, one clock, active-low async reset. */
`timescale 1ns/1ps
module arfga_top_checker
   import arfga_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        rst_b_i,
   input wire logic [7:0]  addr_i,
   input wire logic [7:0]  wr_data_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [7:0]  rd_data_o,
   input wire logic [11:0] sample_i,
   input wire logic        sample_valid_i,
   input wire logic [15:0] result_o,
   input wire logic        result_ready_o,
   input wire logic        gain_access_o,
   input wire logic [7:0]  gain_upper_o,
   input wire logic [3:0]  gain_lower_o,
   input wire logic        gain_add_o
);
   logic [7:0] cfg_r, ctl_r, gsel_r, wd_r;
   logic       single, gw;
   // ====
   // shadow of config, control, gain select and last write data
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_r  <= 8'h00;
         ctl_r  <= 8'h00;
         gsel_r <= 8'h00;
         wd_r   <= 8'h00;
      end else begin
         wd_r <= wr_data_i;
         if (wr_i && addr_i == ARFGA_OFF_CONFIG) cfg_r <= wr_data_i;
         if (wr_i && addr_i == ARFGA_OFF_CONTROL) ctl_r <= wr_data_i;
         if (wr_i && gain_access_o && addr_i == ARFGA_OFF_RES_HI) gsel_r <= wr_data_i;
      end
   end
   assign single = sample_valid_i && cfg_r[2:1] == 2'h0;
   assign gw     = wr_i && gain_access_o && addr_i == ARFGA_OFF_RES_LO;
   // ====
   // assertions
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   rd_idle_a: assert property (!rd_i |=> rd_data_o == 8'h00)
      else $error("read data not zero without a read");
   single_latency_a: assert property (single |-> ##2 result_ready_o)
      else $error("single result not ready two cycles after sample");
   right_format_a: assert property (single && !ctl_r[2] |->
      ##2 result_o == {4'h0, $past(sample_i, 2)}) else $error("right format wrong");
   left_format_a: assert property (single && ctl_r[2] |->
      ##2 result_o == {$past(sample_i, 2), 4'h0}) else $error("left format wrong");
   ready_cause_a: assert property (result_ready_o |-> $past(sample_valid_i, 2))
      else $error("result ready without a sample");
   gain_mode_a: assert property (wr_i && addr_i == ARFGA_OFF_CONFIG |=>
      gain_access_o == cfg_r[0]) else $error("gain mode does not follow config");
   gain_upper_a: assert property (gw && gsel_r == ARFGA_GADDR_UPPER |=>
      gain_upper_o == wd_r) else $error("gain upper not loaded");
   gain_lower_a: assert property (gw && gsel_r == ARFGA_GADDR_LOWER |=>
      gain_lower_o == wd_r[7:4]) else $error("gain lower not loaded");
   gain_add_a: assert property (gw && gsel_r == ARFGA_GADDR_ADD |=>
      gain_add_o == wd_r[0]) else $error("gain add not loaded");
   gain_guard_a: assert property (wr_i && !gain_access_o |=> $stable(gain_upper_o) &&
      $stable(gain_lower_o) && $stable(gain_add_o)) else $error("gain changed outside mode");
   cover property (result_ready_o && cfg_r[2:1] != 2'h0);
   cover property (gw);
   cover property (single && ctl_r[2]);
endmodule // arfga_top_checker

bind arfga_top arfga_top_checker u_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
   .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sample_i(sample_i),
   .sample_valid_i(sample_valid_i), .result_o(result_o), .result_ready_o(result_ready_o),
   .gain_access_o(gain_access_o), .gain_upper_o(gain_upper_o),
   .gain_lower_o(gain_lower_o), .gain_add_o(gain_add_o));

/* File: testbench/arfga_core_model.sv */
/* arfga_core_model: converter core stand-in issuing sample pulses.
   assumes: bench pulses start_i with code, count and gap held. */
`timescale 1ns/1ps
module arfga_core_model (
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic        start_i,
   input  wire logic [11:0] code_i,
   input  wire logic [4:0]  count_i,
   input  wire logic [3:0]  gap_i,
   output logic      [11:0] sample_o,
   output logic             sample_valid_o
);
   logic [4:0]  left_r;
   logic [3:0]  wait_r;
   logic [11:0] last_r;
   // ====
   // pulse sequencer, gap cycles between samples
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         left_r         <= 5'h00;
         wait_r         <= 4'h0;
         last_r         <= 12'h000;
         sample_valid_o <= 1'h0;
      end else begin
         sample_valid_o <= 1'h0;
         if (start_i) begin
            left_r <= count_i;
            wait_r <= gap_i;
         end else if (left_r != 5'h00) begin
            if (wait_r == 4'h0) begin
               sample_valid_o <= 1'h1;
               last_r         <= code_i;
               left_r         <= left_r - 5'h01;
               wait_r         <= gap_i;
            end else begin
               wait_r <= wait_r - 4'h1;
            end
         end
      end
   end
   // data shows inverted junk outside the valid pulse
   assign sample_o = sample_valid_o ? last_r : ~last_r;
endmodule // arfga_core_model

/* File: testbench/arfga_top_tb_top.sv */
/* arfga_top_tb_top: self-checking bench for arfga_top.
   assumes: arfga_core_model as converter core, checker bound. */
`timescale 1ns/1ps
module arfga_top_tb_top
   import arfga_pkg::*;
;
   logic        clock_i = 1'h0;
   logic        rst_b_i = 1'h0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'h0;
   logic        rd = 1'h0;
   logic        start = 1'h0;
   logic [11:0] code = 12'h000;
   logic [4:0]  count = 5'h00;
   logic [3:0]  gap = 4'h0;
   logic [7:0]  rd_data, gup, rdv;
   logic [11:0] sample;
   logic [3:0]  glo;
   logic        sample_valid, ready, gacc, gadd;
   logic [15:0] result, last_e;
   int          n_fail = 0;
   int          checks = 0;
   int          cyc = 0;

   always #2 clock_i = ~clock_i;

   arfga_top u_dut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
      .rd_i(rd), .rd_data_o(rd_data), .sample_i(sample), .sample_valid_i(sample_valid),
      .result_o(result), .result_ready_o(ready), .gain_access_o(gacc),
      .gain_upper_o(gup), .gain_lower_o(glo), .gain_add_o(gadd));
   arfga_core_model u_core (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .start_i(start), .code_i(code),
      .count_i(count), .gap_i(gap), .sample_o(sample), .sample_valid_o(sample_valid));

   // ====
   // bus and compare tasks
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clock_i);
      wr <= 1'h0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clock_i);
      rd <= 1'h0;
      #1;
      d = rd_data;
   endtask
   task automatic conv(input logic [11:0] c, input logic [4:0] n, input logic [15:0] e);
      int          pulses;
      logic [15:0] old;
      pulses = 0;
      old    = result;
      @(posedge clock_i);
      code  <= c;
      count <= n;
      gap   <= (n == 5'h01) ? 4'h0 : 4'h3;
      start <= 1'h1;
      @(posedge clock_i);
      start <= 1'h0;
      repeat (100) begin
         @(posedge clock_i);
         #1;
         if (ready === 1'h1) pulses++;
         else if (pulses == 0 && result !== old) pulses = 9;
      end
      chk("ready pulses", 16'h0001, 16'(pulses));
      chk("result", e, result);
      rd_reg(ARFGA_OFF_RES_HI, rdv);
      chk("high byte", {8'h00, e[15:8]}, {8'h00, rdv});
      rd_reg(ARFGA_OFF_STATUS, rdv);
      chk("status new", 16'h0002, {8'h00, rdv});
      rd_reg(ARFGA_OFF_RES_LO, rdv);
      chk("low byte", {8'h00, e[7:0]}, {8'h00, rdv});
      rd_reg(ARFGA_OFF_STATUS, rdv);
      chk("status clear", 16'h0000, {8'h00, rdv});
      last_e = e;
   endtask

   // ====
   // scenarios
   task automatic t_reset();
      logic [7:0] a;
      for (int i = 0; i < 6; i++) begin
         a = (i == 5) ? 8'h10 : 8'(i);
         rd_reg(a, rdv);
         chk("reset read", 16'h0000, {8'h00, rdv});
      end
      $display("test reset done");
   endtask
   task automatic t_single();
      logic [11:0] cs [4] = '{12'hfff, 12'h800, 12'h7ff, 12'h000};
      wr_reg(ARFGA_OFF_CONFIG, 8'h00);
      for (int j = 0; j < 2; j++) begin
         wr_reg(ARFGA_OFF_CONTROL, j ? 8'h04 : 8'h00);
         foreach (cs[k]) conv(cs[k], 5'h01, j ? {cs[k], 4'h0} : {4'h0, cs[k]});
      end
      $display("test single done");
   endtask
   task automatic t_series();
      logic [11:0] cs [2] = '{12'hfff, 12'h7ff};
      wr_reg(ARFGA_OFF_CONTROL, 8'h00);
      for (int r = 1; r < 4; r++) begin
         wr_reg(ARFGA_OFF_CONFIG, 8'(r << 1));
         foreach (cs[k]) conv(cs[k], 5'(4 << (r - 1)), 16'(cs[k]) << (r + 1));
      end
      $display("test series done");
   endtask
   task automatic t_abort();
      logic [15:0] old;
      wr_reg(ARFGA_OFF_CONFIG, 8'h02);
      old = result;
      @(posedge clock_i);
      code  <= 12'hfff;
      count <= 5'h02;
      gap   <= 4'h3;
      start <= 1'h1;
      @(posedge clock_i);
      start <= 1'h0;
      repeat (20) @(posedge clock_i);
      #1;
      chk("partial kept", old, result);
      rd_reg(ARFGA_OFF_STATUS, rdv);
      chk("partial status", 16'h0021, {8'h00, rdv});
      wr_reg(ARFGA_OFF_CONFIG, 8'h04);
      conv(12'h001, 5'h08, 16'h0008);
      $display("test abort done");
   endtask
   task automatic t_gain();
      logic [7:0] sq [8] = '{8'h04, 8'h6c, 8'h07, 8'ha0, 8'h08, 8'h01, 8'h05, 8'h00};
      wr_reg(ARFGA_OFF_CONFIG, 8'h01);
      chk("gain mode", 16'h0001, {15'h0000, gacc});
      for (int i = 0; i < 8; i += 2) begin
         wr_reg(ARFGA_OFF_RES_HI, sq[i]);
         wr_reg(ARFGA_OFF_RES_LO, sq[i + 1]);
      end
      chk("gain upper", 16'h006c, {8'h00, gup});
      chk("gain lower", 16'h000a, {12'h000, glo});
      chk("gain add", 16'h0001, {15'h0000, gadd});
      chk("result kept", last_e, result);
      rd_reg(ARFGA_OFF_RES_LO, rdv);
      chk("gain read", {8'h00, last_e[7:0]}, {8'h00, rdv});
      wr_reg(ARFGA_OFF_CONFIG, 8'h00);
      chk("gain mode off", 16'h0000, {15'h0000, gacc});
      wr_reg(ARFGA_OFF_RES_HI, 8'h12);
      wr_reg(ARFGA_OFF_RES_LO, 8'h34);
      chk("result write", 16'h1234, result);
      chk("gain kept", 16'h006c, {8'h00, gup});
      $display("test gain done");
   endtask

   // ====
   // run control
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clock_i);
      rst_b_i <= 1'h1;
      t_reset();
      t_single();
      t_series();
      t_abort();
      t_gain();
      finish_test();
   end
endmodule // arfga_top_tb_top
